// >>> core/sfsp_map.svh
/*
  Constants of the slave FIFO port: bus widths, endpoint count, FIFO depth.
  Assumes inclusion by the package and by the port module only.
*/
`ifndef SFSP_MAP_SVH
`define SFSP_MAP_SVH

`define SFSP_DATA_W   16
`define SFSP_SEL_W    3
`define SFSP_EP_N     8
`define SFSP_PTR_W    4
`define SFSP_DEPTH    16
`define SFSP_CNT_W    5
`define SFSP_MEM_W    7
`define SFSP_CNT_FULL 5'h10
`define SFSP_CNT_ZERO 5'h00
`define SFSP_CNT_ONE  5'h01

`endif

// >>> core/sfsp_pkg.sv
/*
  Types shared by the slave FIFO port.
  Assumes sfsp_map.svh is on the include path.
*/
`include "sfsp_map.svh"

package sfsp_pkg;

	typedef logic [`SFSP_DATA_W-1:0] sfsp_word_t;
	typedef logic [`SFSP_SEL_W-1:0]  sfsp_sel_t;
	typedef logic [`SFSP_PTR_W-1:0]  sfsp_ptr_t;
	typedef logic [`SFSP_CNT_W-1:0]  sfsp_cnt_t;
	typedef logic [`SFSP_MEM_W-1:0]  sfsp_addr_t;

endpackage

// >>> core/sfsp_port.sv
/*
  Slave FIFO port: eight endpoint FIFOs written and read by an external
  master on its interface clock, with manual and automatic packet commit.
  Assumes all master-side pins are synchronous to interface_clock, the core-side
  auto-commit settings are static while traffic runs, and a tri-state
  buffer outside resolves the data pin from fifoDataOe_n.
*/
`timescale 1ns/1ps
`include "sfsp_map.svh"

module sfsp_port (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 interface_clock,
	input  wire logic                 port_select_n,
	input  wire logic                 bus_drive_enable,
	input  wire logic                 read_strobe,
	input  wire logic                 write_strobe,
	input  wire logic                 packet_commit_strobe,
	input  wire sfsp_pkg::sfsp_sel_t  endpoint_select,
	input  wire sfsp_pkg::sfsp_word_t fifoDataIn,
	output wire sfsp_pkg::sfsp_word_t  fifoDataOut,
	output logic                      fifoDataOe_n,
	output logic                      emptyFlag,
	output logic                      fullFlag,
	input  wire logic                 autoMode,
	input  wire sfsp_pkg::sfsp_cnt_t  auto_commit_length,
	output logic                      commitPulse,
	output wire sfsp_pkg::sfsp_sel_t  commitEndpoint,
	output wire sfsp_pkg::sfsp_cnt_t  commitLength
);

	function automatic sfsp_pkg::sfsp_addr_t memIndex(
		input sfsp_pkg::sfsp_sel_t ep,
		input sfsp_pkg::sfsp_ptr_t ptr
	);
		memIndex = {ep, ptr};
	endfunction

	// Link-domain reset and settings, brought over by two flip-flops each.
	// Only the second flip-flop of each pair is read by the link logic.
	// The settings carry no handshake, so they must be static while the
	// master moves data; a change mid-packet may be seen bit by bit.
	logic                 rstMeta_q;
	logic                 rstMeta_d;
	logic                 rstLink_q;
	logic                 rstLink_d;
	logic [`SFSP_CNT_W:0] cfgMeta_q;
	logic [`SFSP_CNT_W:0] cfgMeta_d;
	logic [`SFSP_CNT_W:0] cfgSync_q;
	logic [`SFSP_CNT_W:0] cfgSync_d;

	always_comb begin
		rstMeta_d = sys_rst;
		rstLink_d = rstMeta_q;
		cfgMeta_d = {autoMode, auto_commit_length};
		cfgSync_d = cfgMeta_q;
	end

	always_ff @(posedge interface_clock) begin
		rstMeta_q <= rstMeta_d;
		rstLink_q <= rstLink_d;
		cfgMeta_q <= cfgMeta_d;
		cfgSync_q <= cfgSync_d;
	end

	// Link-domain FIFO storage and per-endpoint state.
	sfsp_pkg::sfsp_word_t mem [0:`SFSP_EP_N*`SFSP_DEPTH-1];
	sfsp_pkg::sfsp_ptr_t  wrPtr_q   [`SFSP_EP_N];
	sfsp_pkg::sfsp_ptr_t  wrPtr_d   [`SFSP_EP_N];
	sfsp_pkg::sfsp_ptr_t  rdPtr_q   [`SFSP_EP_N];
	sfsp_pkg::sfsp_ptr_t  rdPtr_d   [`SFSP_EP_N];
	sfsp_pkg::sfsp_cnt_t  count_q   [`SFSP_EP_N];
	sfsp_pkg::sfsp_cnt_t  count_d   [`SFSP_EP_N];
	sfsp_pkg::sfsp_cnt_t  pending_q [`SFSP_EP_N];
	sfsp_pkg::sfsp_cnt_t  pending_d [`SFSP_EP_N];

	sfsp_pkg::sfsp_word_t dataOut_q;
	sfsp_pkg::sfsp_word_t dataOut_d;
	logic                 oeN_q;
	logic                 oeN_d;
	logic                 empty_q;
	logic                 empty_d;
	logic                 full_q;
	logic                 full_d;
	logic                 commitTgl_q;
	logic                 commitTgl_d;
	sfsp_pkg::sfsp_sel_t  linkEp_q;
	sfsp_pkg::sfsp_sel_t  linkEp_d;
	sfsp_pkg::sfsp_cnt_t  linkLen_q;
	sfsp_pkg::sfsp_cnt_t  linkLen_d;

	logic                 readGo;
	logic                 writeGo;
	logic                 autoHit;
	logic                 commitNow;
	sfsp_pkg::sfsp_cnt_t  pendNext;
	sfsp_pkg::sfsp_sel_t  sel;

	always_comb begin
		sel       = endpoint_select;
		readGo    = read_strobe && !port_select_n
		            && (count_q[sel] != `SFSP_CNT_ZERO);
		writeGo   = write_strobe && !port_select_n
		            && (count_q[sel] != `SFSP_CNT_FULL);
		pendNext  = writeGo ? pending_q[sel] + `SFSP_CNT_ONE
		                    : pending_q[sel];
		autoHit   = cfgSync_q[`SFSP_CNT_W] && writeGo
		            && (cfgSync_q[`SFSP_CNT_W-1:0] != `SFSP_CNT_ZERO)
		            && (pendNext == cfgSync_q[`SFSP_CNT_W-1:0]);
		// An automatic commit and a packet end on the same edge merge into
		// one commit, so no empty packet is committed right after it.
		commitNow = autoHit || packet_commit_strobe;
		for (int i = 0; i < `SFSP_EP_N; i++) begin
			wrPtr_d[i]   = wrPtr_q[i];
			rdPtr_d[i]   = rdPtr_q[i];
			count_d[i]   = count_q[i];
			pending_d[i] = pending_q[i];
		end
		if (writeGo) begin
			wrPtr_d[sel] = wrPtr_q[sel] + 4'h1;
		end
		if (readGo) begin
			rdPtr_d[sel] = rdPtr_q[sel] + 4'h1;
		end
		count_d[sel]   = count_q[sel] + {4'h0, writeGo}
		                 - {4'h0, readGo};
		pending_d[sel] = commitNow ? `SFSP_CNT_ZERO : pendNext;
		commitTgl_d    = commitNow ? !commitTgl_q : commitTgl_q;
		linkEp_d       = commitNow ? sel : linkEp_q;
		linkLen_d      = commitNow ? pendNext : linkLen_q;
		// Prefetch the word the read pointer will point at after this edge.
		dataOut_d = mem[memIndex(sel, rdPtr_d[sel])];
		oeN_d     = !bus_drive_enable;
		empty_d   = (count_d[sel] == `SFSP_CNT_ZERO);
		full_d    = (count_d[sel] == `SFSP_CNT_FULL);
		if (rstLink_q) begin
			for (int i = 0; i < `SFSP_EP_N; i++) begin
				wrPtr_d[i]   = 4'h0;
				rdPtr_d[i]   = 4'h0;
				count_d[i]   = `SFSP_CNT_ZERO;
				pending_d[i] = `SFSP_CNT_ZERO;
			end
			commitTgl_d = 1'b0;
			linkEp_d    = 3'h0;
			linkLen_d   = `SFSP_CNT_ZERO;
			oeN_d       = 1'b1;
			empty_d     = 1'b1;
			full_d      = 1'b0;
			dataOut_d   = 16'h0000;
		end
	end

	always_ff @(posedge interface_clock) begin
		if (writeGo && !rstLink_q) begin
			mem[memIndex(sel, wrPtr_q[sel])] <= fifoDataIn;
		end
	end

	always_ff @(posedge interface_clock) begin
		wrPtr_q     <= wrPtr_d;
		rdPtr_q     <= rdPtr_d;
		count_q     <= count_d;
		pending_q   <= pending_d;
		dataOut_q   <= dataOut_d;
		oeN_q       <= oeN_d;
		empty_q     <= empty_d;
		full_q      <= full_d;
		commitTgl_q <= commitTgl_d;
		linkEp_q    <= linkEp_d;
		linkLen_q   <= linkLen_d;
	end

	// The bus word is reloaded on every link edge; only the enable decides whether it is seen.
	assign fifoDataOut  = dataOut_q;
	assign fifoDataOe_n = oeN_q;
	assign emptyFlag    = empty_q;
	assign fullFlag     = full_q;

	// Core domain: commit toggle crosses by two flip-flops plus edge detect.
	// Endpoint and length are held in the link domain until the next commit,
	// which is many core cycles away, so they are stable when sampled.
	logic                tglMeta_q;
	logic                tglMeta_d;
	logic                tglSync_q;
	logic                tglSync_d;
	logic                tglOld_q;
	logic                tglOld_d;
	logic                pulse_q;
	logic                pulse_d;
	sfsp_pkg::sfsp_sel_t ep_q;
	sfsp_pkg::sfsp_sel_t ep_d;
	sfsp_pkg::sfsp_cnt_t len_q;
	sfsp_pkg::sfsp_cnt_t len_d;

	always_comb begin
		tglMeta_d = commitTgl_q;
		tglSync_d = tglMeta_q;
	end

	// The toggle changes at most once per link cycle, which is far slower
	// than the core clock, so no commit can be missed by the edge detect.
	always_ff @(posedge core_clk) begin
		tglMeta_q <= tglMeta_d;
		tglSync_q <= tglSync_d;
	end

	always_comb begin
		pulse_d  = tglSync_q ^ tglOld_q;
		tglOld_d = tglSync_q;
		ep_d     = pulse_d ? linkEp_q : ep_q;
		len_d    = pulse_d ? linkLen_q : len_q;
		if (sys_rst) begin
			pulse_d  = 1'b0;
			tglOld_d = 1'b0;
			ep_d     = 3'h0;
			len_d    = `SFSP_CNT_ZERO;
		end
	end

	always_ff @(posedge core_clk) begin
		pulse_q  <= pulse_d;
		tglOld_q <= tglOld_d;
		ep_q     <= ep_d;
		len_q    <= len_d;
	end

	assign commitPulse    = pulse_q;
	assign commitEndpoint = ep_q;
	assign commitLength   = len_q;

endmodule

// >>> verif/sfsp_port_monitor.sv
/*
  Link-side checks of the slave FIFO port pins and flags.
  Assumes binding into sfsp_port and a live port 7 link edges after reset.
*/
`timescale 1ns/1ps
module sfsp_port_monitor (
	input wire logic                sys_rst,
	input wire logic                interface_clock,
	input wire logic                port_select_n,
	input wire logic                bus_drive_enable,
	input wire logic                read_strobe,
	input wire logic                write_strobe,
	input wire sfsp_pkg::sfsp_sel_t endpoint_select,
	input wire logic                fifoDataOe_n,
	input wire logic                emptyFlag,
	input wire logic                fullFlag
);
	logic [2:0] upQ, upD;
	logic       ok, rdGo, wrGo;
	default clocking @(posedge interface_clock); endclocking
	default disable iff (sys_rst);
	// Counts link edges after reset so checks start once the port is live.
	always_comb upD = sys_rst ? 3'h0 : upQ + {2'h0, upQ != 3'h7};
	always_ff @(posedge interface_clock) upQ <= upD;
	assign ok = upQ == 3'h7;
	assign rdGo = ok && !port_select_n && read_strobe && !write_strobe;
	assign wrGo = ok && !port_select_n && write_strobe && !read_strobe;
	sequence s_keep;
		ok && $stable(endpoint_select);
	endsequence
	chk_drive_on: assert property (
		ok && bus_drive_enable |=> !fifoDataOe_n) else $error("bus not driven");
	chk_drive_off: assert property (
		ok && !bus_drive_enable |=> fifoDataOe_n) else $error("bus not released");
	chk_flags_excl: assert property (
		!(emptyFlag && fullFlag)) else $error("empty and full together");
	chk_write_fill: assert property (
		wrGo |=> !emptyFlag) else $error("empty after a write");
	chk_read_drain: assert property (
		s_keep ##0 (fullFlag && rdGo) |=> !fullFlag) else $error("full after read");
	chk_full_refuse: assert property (
		s_keep ##0 (fullFlag && wrGo) |=> fullFlag) else $error("full dropped");
	chk_empty_refuse: assert property (
		s_keep ##0 (emptyFlag && rdGo) |=> emptyFlag) else $error("empty dropped");
	chk_select_idle: assert property (
		s_keep ##0 port_select_n |=> $stable(emptyFlag) && $stable(fullFlag))
		else $error("flags moved while deselected");
endmodule
bind sfsp_port sfsp_port_monitor i_mon (.sys_rst, .interface_clock,
	.port_select_n, .bus_drive_enable, .read_strobe, .write_strobe,
	.endpoint_select, .fifoDataOe_n, .emptyFlag, .fullFlag);

// >>> verif/sfsp_master.sv
/*
  External master model: makes the link clock and drives the port pins.
  Assumes the bench calls step once for every link cycle it wants.
*/
`timescale 1ns/1ps
module sfsp_master (
	output logic                 interface_clock,
	output logic                 port_select_n,
	output logic                 bus_drive_enable,
	output logic                 read_strobe,
	output logic                 write_strobe,
	output logic                 packet_commit_strobe,
	output sfsp_pkg::sfsp_sel_t  endpoint_select,
	output sfsp_pkg::sfsp_word_t fifoDataIn
);
	initial begin
		interface_clock = 1'b0;
		port_select_n = 1'b1;
		{bus_drive_enable, read_strobe, write_strobe} = 3'h0;
		{packet_commit_strobe, endpoint_select, fifoDataIn} = 20'h0;
	end
	always #62.5 interface_clock = ~interface_clock;
	// Released data lines toggle so a stale word stored without a write shows up in the checks.
	task step(input logic cs, oe, rd, wr, pe, input sfsp_pkg::sfsp_sel_t e,
		input sfsp_pkg::sfsp_word_t d);
		@(posedge interface_clock);
		#1;
		port_select_n = !cs;
		bus_drive_enable = oe;
		read_strobe = rd;
		write_strobe = wr;
		packet_commit_strobe = pe;
		endpoint_select = e;
		fifoDataIn = wr ? d : ~fifoDataIn;
	endtask
endmodule

// >>> verif/test_slave_fifo_sync_port.sv
/*
  Self-checking bench of the slave FIFO port driven by the master model.
  Assumes sfsp_pkg, sfsp_port, sfsp_master and the monitor are compiled.
*/
`timescale 1ns/1ps
module test_slave_fifo_sync_port;
	logic core_clk = 1'b0, sys_rst = 1'b1, autoMode = 1'b0, fullFlag;
	logic interface_clock, port_select_n, bus_drive_enable, read_strobe;
	logic write_strobe, packet_commit_strobe, fifoDataOe_n, emptyFlag;
	logic commitPulse;
	sfsp_pkg::sfsp_sel_t  endpoint_select, commitEndpoint;
	sfsp_pkg::sfsp_word_t fifoDataIn, fifoDataOut, w, q[8][$];
	sfsp_pkg::sfsp_cnt_t  auto_commit_length = 5'h00, commitLength;
	int                   errCount, checks, pulses, expPulses, n;
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) pulses <= pulses + (commitPulse === 1'b1);
	sfsp_master i_mst (.interface_clock, .port_select_n, .bus_drive_enable,
		.read_strobe, .write_strobe, .packet_commit_strobe, .endpoint_select,
		.fifoDataIn);
	sfsp_port i_dut (.core_clk, .sys_rst, .interface_clock, .port_select_n,
		.bus_drive_enable, .read_strobe, .write_strobe, .packet_commit_strobe,
		.endpoint_select, .fifoDataIn, .fifoDataOut, .fifoDataOe_n, .emptyFlag,
		.fullFlag, .autoMode, .auto_commit_length, .commitPulse,
		.commitEndpoint, .commitLength);
	task chk(input sfsp_pkg::sfsp_word_t seen, exp);
		checks++;
		if (seen !== exp) begin
			errCount++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task commit_wait(input sfsp_pkg::sfsp_sel_t e, input sfsp_pkg::sfsp_cnt_t l);
		expPulses++;
		repeat (2) i_mst.step(0, 0, 0, 0, 0, e, 16'h0);
		chk(16'(pulses), 16'(expPulses));
		chk(commitEndpoint, e);
		chk(commitLength, l);
	endtask
	initial begin
		void'($urandom(35));
		repeat (5) @(posedge interface_clock);
		@(posedge core_clk);
		#1 sys_rst = 1'b0;
		repeat (4) i_mst.step(0, 0, 0, 0, 0, 3'h0, 16'h0);
		chk(emptyFlag, 1'b1);
		chk(fifoDataOe_n, 1'b1);
		for (int e = 0; e < 8; e++) begin
			n = (e == 0) ? 16 : $urandom_range(1, 15);
			for (int i = 0; i < n; i++) begin
				w = 16'($urandom);
				q[e].push_back(w);
				i_mst.step(1, 0, 0, 1, e[0] && i == n - 1, e[2:0], w);
			end
			if (!e[0])
				i_mst.step(1, 0, 0, e == 0, 1, e[2:0], 16'hffff);
			commit_wait(e[2:0], n[4:0]);
			chk(fullFlag, n == 16);
		end
		$display("write and commit test finished");
		for (int e = 7; e >= 0; e--) begin
			i_mst.step(0, 1, 0, 0, 0, e[2:0], 16'h0);
			i_mst.step(0, 0, 0, 0, 0, e[2:0], 16'h0);
			chk(fifoDataOe_n, 1'b0);
			chk(fifoDataOut, q[e][0]);
			i_mst.step(0, 1, 1, 0, 0, e[2:0], 16'h0);
			chk(fifoDataOe_n, 1'b1);
			for (int i = 0; i < q[e].size(); i++) begin
				i_mst.step(1, 1, 1, 0, 0, e[2:0], 16'h0);
				chk(fifoDataOut, q[e][i]);
			end
			i_mst.step(1, 0, 1, 0, 0, e[2:0], 16'h0);
			chk(emptyFlag, 1'b1);
		end
		$display("burst read test finished");
		autoMode = 1'b1;
		n = $urandom_range(2, 8);
		auto_commit_length = n[4:0];
		for (int i = 0; i < n; i++)
			i_mst.step(1, 0, 0, 1, 0, 3'h5, 16'(i));
		commit_wait(3'h5, n[4:0]);
		i_mst.step(1, 0, 0, 1, 1, 3'h5, 16'h00a5);
		commit_wait(3'h5, 5'h01);
		$display("auto commit test finished");
		complete_run();
	end
endmodule
